// ### rtl/usb_suspend_resume_power_ctl.sv
// suspend detection, power-down and wakeup/resume timing
// Functional notes
// - core clock is crystal times four
// - oscillator off while powered down
// - stable flag only after settle time
// - power-down request stops oscillator and pll
// - host frame markers stop when disabled
// - 3ms idle sets suspend; gated interrupt
// - suspend alone never powers down
// - power-down keeps irq, watches d+ and spi
// - host resume drives 20ms, then event
// - host sees remote wakeup, sets flag
// - clearing power-down request or reset wakes
// - remote wake restarts osc, 10ms k-state
// - remote wake waits 5ms bus idle
// - resume end sets remote wake done
// - d+ fall wakes when enabled
`timescale 1ns/10ps
module usb_suspend_resume_power_ctl #(
  parameter int unsigned SUSPEND_CYC   = usb_pm_pkg::SUSPEND_CYC,
  parameter int unsigned FRAME_CYC     = usb_pm_pkg::FRAME_CYC,
  parameter int unsigned HOST_RSM_CYC  = usb_pm_pkg::HOST_RSM_CYC,
  parameter int unsigned RWU_K_CYC     = usb_pm_pkg::RWU_K_CYC,
  parameter int unsigned RWU_IDLE_CYC  = usb_pm_pkg::RWU_IDLE_CYC,
  parameter int unsigned OSC_SETTLE_CYC = usb_pm_pkg::OSC_SETTLE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_host_mode,
  input  wire logic i_power_down_request,
  input  wire logic i_frame_marker_enable,
  input  wire logic i_host_resume_request,
  input  wire logic i_remote_wake_request,
  input  wire logic i_host_activity_wake_enable,
  input  wire logic i_suspend_irq_enable,
  input  wire logic i_global_irq_enable,
  input  wire logic i_bus_activity,
  input  wire logic i_dplus,
  input  wire logic i_remote_wake_seen,
  input  wire logic i_spi_activity,
  input  wire logic i_clr_osc_stable_flag,
  input  wire logic i_clr_suspend_flag,
  input  wire logic i_clr_bus_event_flag,
  input  wire logic i_clr_wake_request_flag,
  input  wire logic i_clr_remote_wake_done_flag,
  output logic      o_osc_enable,
  output logic      o_pll_enable,
  output logic      o_core_clk_ready,
  output logic      o_frame_marker,
  output logic      o_resume_drive,
  output logic      o_powered_down,
  output logic      o_spi_wake,
  output logic      o_osc_stable_flag,
  output logic      o_suspend_flag,
  output logic      o_bus_event_flag,
  output logic      o_wake_request_flag,
  output logic      o_remote_wake_done_flag,
  output logic      o_irq
);
  localparam int unsigned W = usb_pm_pkg::CNT_W;

  typedef enum logic [2:0] {
    ST_RUN, ST_DOWN, ST_SETTLE, ST_IDLE_WAIT, ST_RWU_K, ST_HOST_RSM
  } pm_state_t;

  typedef struct packed {
    pm_state_t   state;
    logic [W-1:0] idle_cnt;
    logic [W-1:0] frame_cnt;
    logic        rwu_pending;
    logic        frame;
    logic        dplus_q;
    logic        rsm_req_q;
    logic        osc_ok;
    logic        suspend;
    logic        bus_event;
    logic        wake_req;
    logic        rwu_done;
    logic        susp_seen;
    logic        pd_armed;
    logic        down_out;
    logic        osc_on;
    logic        pll_on;
    logic        clk_ready;
    logic        resume_out;
    logic        spi_wake;
    logic        irq;
  } pm_regs_t;

  pm_regs_t st_ff;
  pm_regs_t nxt_st;

  logic         tmr_load;
  logic [W-1:0] tmr_count;
  logic         tmr_busy;
  logic         tmr_done;
  logic         tmr_stop;

  localparam int unsigned FLAG_N = 5;
  localparam int unsigned F_OSC  = 0;
  localparam int unsigned F_SUSP = 1;
  localparam int unsigned F_BUS  = 2;
  localparam int unsigned F_WAKE = 3;
  localparam int unsigned F_RWU  = 4;

  logic [FLAG_N-1:0] flag_set;
  logic [FLAG_N-1:0] flag_clr;
  logic [FLAG_N-1:0] flag_cur;
  logic [FLAG_N-1:0] flag_nxt;
  logic              susp_hit;
  logic              frame_run;
  logic              rsm_edge;
  logic              go_down;
  logic              dplus_fall;
  logic              wake_sw;
  logic              wake_rwu;
  logic              wake_dplus;
  logic              wake_any;

  pm_timer #(
    .W(W)
  ) u_timer (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .i_stop  (tmr_stop),
    .o_busy  (tmr_busy),
    .o_done  (tmr_done)
  );

  // peripheral suspend detect; no power-down here
  assign susp_hit  = !i_host_mode && !st_ff.susp_seen
                     && st_ff.idle_cnt >= W'(SUSPEND_CYC);
  assign frame_run = i_host_mode && i_frame_marker_enable && st_ff.state == ST_RUN;
  assign rsm_edge  = i_host_mode && i_host_resume_request && !st_ff.rsm_req_q;
  assign go_down   = i_power_down_request && st_ff.pd_armed && !i_remote_wake_request;

  // wake sources while powered down
  assign dplus_fall = st_ff.dplus_q && !i_dplus;
  assign wake_sw    = !i_power_down_request;
  assign wake_rwu   = i_remote_wake_request;
  assign wake_dplus = i_host_activity_wake_enable && dplus_fall;
  assign wake_any   = wake_sw || wake_rwu || wake_dplus;

  // sticky flags, set wins over clear
  assign flag_set[F_OSC]  = st_ff.state == ST_SETTLE && tmr_done;
  assign flag_set[F_SUSP] = susp_hit;
  assign flag_set[F_BUS]  = st_ff.state == ST_HOST_RSM && tmr_done;
  assign flag_set[F_WAKE] = i_host_mode && i_remote_wake_seen;
  assign flag_set[F_RWU]  = st_ff.state == ST_RWU_K && tmr_done;
  assign flag_clr[F_OSC]  = i_clr_osc_stable_flag;
  assign flag_clr[F_SUSP] = i_clr_suspend_flag;
  assign flag_clr[F_BUS]  = i_clr_bus_event_flag;
  assign flag_clr[F_WAKE] = i_clr_wake_request_flag;
  assign flag_clr[F_RWU]  = i_clr_remote_wake_done_flag;
  assign flag_cur[F_OSC]  = st_ff.osc_ok;
  assign flag_cur[F_SUSP] = st_ff.suspend;
  assign flag_cur[F_BUS]  = st_ff.bus_event;
  assign flag_cur[F_WAKE] = st_ff.wake_req;
  assign flag_cur[F_RWU]  = st_ff.rwu_done;

  for (genvar g = 0; g < FLAG_N; g++) begin : g_flag
    assign flag_nxt[g] = flag_set[g] || (flag_cur[g] && !flag_clr[g]);
  end

  always_comb begin
    nxt_st    = st_ff;
    tmr_load  = 1'b0;
    tmr_stop  = 1'b0;
    tmr_count = '0;
    nxt_st.dplus_q   = i_dplus;
    nxt_st.rsm_req_q = i_host_resume_request;
    nxt_st.frame     = 1'b0;

    // bus idle counter, saturating
    if (i_bus_activity) begin
      nxt_st.idle_cnt  = '0;
      nxt_st.susp_seen = 1'b0;
    end else if (st_ff.idle_cnt != {W{1'b1}}) begin
      nxt_st.idle_cnt = st_ff.idle_cnt + W'(1);
    end

    // one suspend per idle period
    if (susp_hit) begin
      nxt_st.susp_seen = 1'b1;
    end

    // host frame marker generator
    if (frame_run) begin
      if (st_ff.frame_cnt >= W'(FRAME_CYC - 1)) begin
        nxt_st.frame_cnt = '0;
        nxt_st.frame     = 1'b1;
      end else begin
        nxt_st.frame_cnt = st_ff.frame_cnt + W'(1);
      end
    end else begin
      nxt_st.frame_cnt = '0;
    end

    nxt_st.osc_ok    = flag_nxt[F_OSC];
    nxt_st.suspend   = flag_nxt[F_SUSP];
    nxt_st.bus_event = flag_nxt[F_BUS];
    nxt_st.wake_req  = flag_nxt[F_WAKE];
    nxt_st.rwu_done  = flag_nxt[F_RWU];

    // power-down re-armed once request released
    if (!i_power_down_request) begin
      nxt_st.pd_armed = 1'b1;
    end

    unique case (st_ff.state)
      ST_RUN: begin
        if (go_down) begin
          nxt_st.state = ST_DOWN;
          tmr_stop     = 1'b1;
        end else if (rsm_edge) begin
          nxt_st.state = ST_HOST_RSM;
          tmr_load     = 1'b1;
          tmr_count    = W'(HOST_RSM_CYC);
        end else if (!i_host_mode && i_remote_wake_request && !st_ff.rwu_done) begin
          nxt_st.state = ST_IDLE_WAIT;
        end
      end
      ST_DOWN: begin
        // oscillator off; wake sources
        if (wake_any) begin
          nxt_st.state       = ST_SETTLE;
          nxt_st.pd_armed    = 1'b0;
          nxt_st.rwu_pending = wake_rwu;
          tmr_load           = 1'b1;
          tmr_count          = W'(OSC_SETTLE_CYC);
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          nxt_st.state  = st_ff.rwu_pending ? ST_IDLE_WAIT : ST_RUN;
          nxt_st.rwu_pending = 1'b0;
        end
      end
      ST_IDLE_WAIT: begin
        if (!i_remote_wake_request) begin
          nxt_st.state = ST_RUN;
        end else if (st_ff.idle_cnt >= W'(RWU_IDLE_CYC)) begin
          nxt_st.state = ST_RWU_K;
          tmr_load     = 1'b1;
          tmr_count    = W'(RWU_K_CYC);
        end
      end
      ST_RWU_K: begin
        if (tmr_done) begin
          nxt_st.state    = ST_RUN;
        end
      end
      ST_HOST_RSM: begin
        if (tmr_done) begin
          nxt_st.state     = ST_RUN;
        end
      end
      default: nxt_st.state = ST_RUN;
    endcase

    // registered outputs, decoded from next state
    nxt_st.down_out   = nxt_st.state == ST_DOWN;
    nxt_st.osc_on     = nxt_st.state != ST_DOWN;
    nxt_st.pll_on     = nxt_st.state != ST_DOWN;
    nxt_st.clk_ready  = nxt_st.state != ST_DOWN && nxt_st.state != ST_SETTLE;
    nxt_st.resume_out = nxt_st.state == ST_RWU_K || nxt_st.state == ST_HOST_RSM;
    nxt_st.spi_wake   = nxt_st.state == ST_DOWN && i_spi_activity;
    nxt_st.irq        = nxt_st.suspend && i_suspend_irq_enable && i_global_irq_enable;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff         <= '0;
      st_ff.state   <= ST_RUN;
      st_ff.dplus_q <= 1'b1;
      st_ff.osc_on  <= 1'b1;
      st_ff.pll_on  <= 1'b1;
      st_ff.clk_ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_powered_down  = st_ff.down_out;
  assign o_osc_enable    = st_ff.osc_on;
  assign o_pll_enable    = st_ff.pll_on;
  assign o_core_clk_ready = st_ff.clk_ready;
  assign o_frame_marker  = st_ff.frame;
  assign o_resume_drive  = st_ff.resume_out;
  assign o_spi_wake      = st_ff.spi_wake;
  assign o_osc_stable_flag       = st_ff.osc_ok;
  assign o_suspend_flag          = st_ff.suspend;
  assign o_bus_event_flag        = st_ff.bus_event;
  assign o_wake_request_flag     = st_ff.wake_req;
  assign o_remote_wake_done_flag = st_ff.rwu_done;
  assign o_irq = st_ff.irq;
endmodule : usb_suspend_resume_power_ctl

// ### rtl/usb_pm_pkg.sv
// shared constants for the usb suspend/resume power control block
package usb_pm_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned XTAL_HZ       = 12_000_000;
  localparam int unsigned PLL_MULT      = 4;
  localparam int unsigned CORE_HZ       = XTAL_HZ * PLL_MULT;
  localparam int unsigned SUSPEND_US    = 3_000;
  localparam int unsigned FRAME_US      = 1_000;
  localparam int unsigned HOST_RSM_US   = 20_000;
  localparam int unsigned RWU_K_US      = 10_000;
  localparam int unsigned RWU_IDLE_US   = 5_000;
  localparam int unsigned OSC_SETTLE_US = 2_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned SUSPEND_CYC   = SUSPEND_US * CYC_PER_US;
  localparam int unsigned FRAME_CYC     = FRAME_US * CYC_PER_US;
  localparam int unsigned HOST_RSM_CYC  = HOST_RSM_US * CYC_PER_US;
  localparam int unsigned RWU_K_CYC     = RWU_K_US * CYC_PER_US;
  localparam int unsigned RWU_IDLE_CYC  = RWU_IDLE_US * CYC_PER_US;
  localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_US * CYC_PER_US;
  localparam int unsigned CNT_W         = 24;
endpackage : usb_pm_pkg

// ### rtl/pm_timer.sv
// loadable down counter with one-cycle done pulse
`timescale 1ns/10ps
module pm_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  input  wire logic         i_stop,
  output logic              o_busy,
  output logic              o_done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } tmr_state_t;
  tmr_state_t st_ff;
  tmr_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (i_stop) begin
      nxt_st.busy = 1'b0;
    end else if (i_load) begin
      nxt_st.cnt  = i_count;
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy) begin
      if (st_ff.cnt <= W'(1)) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - W'(1);
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_busy = st_ff.busy;
  assign o_done = st_ff.done;
endmodule : pm_timer

// ### tb/pm_chk.sv
// assertion checker for the usb power control block
`timescale 1ns/10ps
module pm_chk (
  input wire logic i_clk, i_srst, i_host_mode, i_power_down_request, i_frame_marker_enable,
  input wire logic i_remote_wake_request, i_host_activity_wake_enable, i_suspend_irq_enable,
  input wire logic i_global_irq_enable, o_osc_enable, o_pll_enable, o_core_clk_ready,
  input wire logic o_frame_marker, o_resume_drive, o_powered_down, o_suspend_flag,
  input wire logic o_bus_event_flag, o_remote_wake_done_flag, o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  osc_off_a: assert property (o_powered_down |-> !o_osc_enable && !o_pll_enable)
    else $error("clock on in power-down");
  irq_gate_a: assert property (o_irq == (o_suspend_flag && $past(i_suspend_irq_enable)
    && $past(i_global_irq_enable))) else $error("irq not gated");
  no_auto_pd_a: assert property ($rose(o_powered_down) |-> $past(i_power_down_request))
    else $error("power-down without request");
  settle_a: assert property ($rose(o_osc_enable) |-> !o_core_clk_ready [*8])
    else $error("ready before settle");
  frame_off_a: assert property (!i_frame_marker_enable [*2] |-> !o_frame_marker)
    else $error("marker while disabled");
  rsm_len_a: assert property ($rose(o_resume_drive) && i_host_mode |-> o_resume_drive [*8])
    else $error("host resume too short");
  bus_ev_a: assert property ($fell(o_resume_drive) && i_host_mode |-> ##[0:1] o_bus_event_flag)
    else $error("no bus event flag");
  rwu_done_a: assert property ($fell(o_resume_drive) && !i_host_mode
    |-> ##[0:1] o_remote_wake_done_flag) else $error("no wake done flag");
  dwake_off_a: assert property (o_powered_down && !i_host_activity_wake_enable
    && !i_remote_wake_request && i_power_down_request |=> o_powered_down)
    else $error("woke without cause");
  cover property ($rose(o_powered_down));
  cover property ($fell(o_resume_drive) && !i_host_mode);
  cover property ($rose(o_irq));
endmodule : pm_chk
bind usb_suspend_resume_power_ctl pm_chk i_chk (.*);

// ### tb/usb_bus_model.sv
// usb bus partner line behaviour
`timescale 1ns/10ps
module usb_bus_model (
  input  wire logic i_busy,
  input  wire logic i_dfall,
  input  wire logic i_rwu,
  output logic      o_act,
  output logic      o_dplus,
  output logic      o_seen
);
  // idle bus pulls d+ high
  assign o_act   = i_busy;
  assign o_dplus = !i_dfall;
  assign o_seen  = i_rwu;
endmodule : usb_bus_model

// ### tb/testbench.sv
// self-checking bench for the usb power control block
`timescale 1ns/10ps
module testbench;
  localparam int N = 20;
  logic i_clk = 0, i_srst = 1, i_host_mode = 0, i_power_down_request = 0, busy = 0;
  logic i_frame_marker_enable = 0, i_host_resume_request = 0, i_remote_wake_request = 0;
  logic i_host_activity_wake_enable = 0, i_suspend_irq_enable = 1, i_global_irq_enable = 0;
  logic i_spi_activity = 0, i_clr_osc_stable_flag = 0, i_clr_suspend_flag = 0, dfall = 0;
  logic i_clr_bus_event_flag = 0, i_clr_wake_request_flag = 0, i_clr_remote_wake_done_flag = 0;
  logic rwu = 0;
  wire i_bus_activity, i_dplus, i_remote_wake_seen, o_osc_enable, o_pll_enable, o_irq;
  wire o_core_clk_ready, o_frame_marker, o_resume_drive, o_powered_down, o_spi_wake;
  wire o_osc_stable_flag, o_suspend_flag, o_bus_event_flag, o_wake_request_flag;
  wire o_remote_wake_done_flag;
  wire [3:0] ev = {o_resume_drive, o_suspend_flag, o_core_clk_ready, o_frame_marker};
  int error_cnt = 0, n_tests = 0, k;
  always #2.5 i_clk = ~i_clk;
  usb_suspend_resume_power_ctl #(N, N, N, N, N, N) i_dut (.*);
  usb_bus_model i_bus (.i_busy(busy), .i_dfall(dfall), .i_rwu(rwu), .o_act(i_bus_activity),
                       .o_dplus(i_dplus), .o_seen(i_remote_wake_seen));
  task automatic chk(input string s, input logic v, input logic e);
    n_tests++;
    if (v !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", s, e, v);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic wt(input int b);
    for (k = 0; k < 400 && ev[b] !== 1'h1; k++) @(negedge i_clk);
    if (k == 400) begin
      error_cnt++;
      $display("ERROR wait %0d expected 1 seen 0", b);
      stop_test();
    end
  endtask : wt
  task automatic len(output int n);
    for (n = 0; n < 400 && o_resume_drive === 1'h1; n++) @(negedge i_clk);
  endtask : len
  initial begin
    cyc(5);
    i_srst = 0;
    chk("osc_on", o_osc_enable, 1'h1);
    chk("flags", |{o_suspend_flag, o_osc_stable_flag, o_bus_event_flag}, 1'h0);
    wt(2);
    chk("susp_time", k >= N - 1 && k <= N + 2, 1'h1);
    chk("irq_off", o_irq, 1'h0);
    i_global_irq_enable = 1;
    cyc(1);
    chk("irq_on", o_irq, 1'h1);
    chk("no_auto_pd", o_powered_down, 1'h0);
    i_clr_suspend_flag = 1;
    i_power_down_request = 1;
    cyc(1);
    i_clr_suspend_flag = 0;
    cyc(1);
    chk("pd", o_powered_down, 1'h1);
    chk("osc_off", o_osc_enable | o_pll_enable, 1'h0);
    i_spi_activity = 1;
    dfall = 1;
    cyc(3);
    chk("spi_wake", o_spi_wake, 1'h1);
    chk("no_dwake", o_powered_down, 1'h1);
    dfall = 0;
    i_spi_activity = 0;
    i_host_activity_wake_enable = 1;
    cyc(2);
    dfall = 1;
    cyc(2);
    chk("dwake", o_osc_enable, 1'h1);
    i_power_down_request = 0;
    wt(1);
    chk("stable", o_osc_stable_flag, 1'h1);
    dfall = 0;
    i_power_down_request = 1;
    cyc(2);
    chk("pd2", o_powered_down, 1'h1);
    i_power_down_request = 0;
    cyc(2);
    chk("clr_wake", o_powered_down, 1'h0);
    i_power_down_request = 1;
    cyc(2);
    i_clr_osc_stable_flag = 1;
    busy = 1;
    i_remote_wake_request = 1;
    cyc(1);
    i_clr_osc_stable_flag = 0;
    cyc(2 * N + 10);
    chk("stable2", o_osc_stable_flag, 1'h1);
    chk("busy_hold", o_resume_drive, 1'h0);
    busy = 0;
    cyc(N - 2);
    chk("idle_hold", o_resume_drive, 1'h0);
    wt(3);
    len(k);
    chk("k_len", k == N + 1, 1'h1);
    cyc(1);
    chk("rwu_done", o_remote_wake_done_flag, 1'h1);
    i_remote_wake_request = 0;
    i_power_down_request = 0;
    i_host_mode = 1;
    i_frame_marker_enable = 1;
    wt(0);
    cyc(1);
    wt(0);
    chk("frame_per", k == N - 1, 1'h1);
    i_frame_marker_enable = 0;
    cyc(2);
    repeat (2 * N) begin
      chk("no_frame", o_frame_marker, 1'h0);
      cyc(1);
    end
    i_host_resume_request = 1;
    wt(3);
    len(k);
    chk("rsm_len", k == N + 1, 1'h1);
    cyc(1);
    chk("bus_event", o_bus_event_flag, 1'h1);
    i_host_resume_request = 0;
    i_clr_bus_event_flag = 1;
    i_frame_marker_enable = 1;
    cyc(1);
    i_clr_bus_event_flag = 0;
    wt(0);
    chk("ev_clr", o_bus_event_flag, 1'h0);
    rwu = 1;
    cyc(2);
    chk("wake_req", o_wake_request_flag, 1'h1);
    i_power_down_request = 1;
    cyc(2);
    chk("pd3", o_powered_down, 1'h1);
    i_srst = 1;
    cyc(2);
    i_srst = 0;
    chk("rst_osc", o_osc_enable, 1'h1);
    chk("rst_flags", o_remote_wake_done_flag | o_bus_event_flag, 1'h0);
    cyc(3);
    chk("rst_stay", o_powered_down, 1'h0);
    stop_test();
  end
endmodule : testbench
